// File: core/dad_defs.svh
// Purpose: address window constants and reset values for the default decoder
// Assumes: 32-bit processor byte addresses
// Notes:   each window is a naturally aligned power-of-two block (base plus mask)
`ifndef DAD_DEFS_SVH
`define DAD_DEFS_SVH

// pci/isa i/o window, 128 KB
`define DAD_PIO_BASE   32'h80000000
`define DAD_PIO_MASK   32'hFFFE0000
// memory controller register block, 64 KB
`define DAD_MC_BASE    32'hFEF80000
`define DAD_MC_MASK    32'hFFFF0000
// host bridge register block, 64 KB
`define DAD_HB_BASE    32'hFEFF0000
`define DAD_HB_MASK    32'hFFFF0000
// boot rom/flash window, top 1 MB
`define DAD_BOOT_BASE  32'hFFF00000
`define DAD_BOOT_MASK  32'hFFF00000

// window index positions in the hit vector
`define DAD_WIN_PIO    0
`define DAD_WIN_MC     1
`define DAD_WIN_HB     2
`define DAD_WIN_BOOT   3
`define DAD_WIN_N      4

// reset values
`define DAD_DEFMAP_RST 1'b1
`define DAD_PCIEN_RST  1'b0
`define DAD_VALID_RST  1'b0
`define DAD_OFFS_RST   20'h00000

`endif

// File: core/dad_pkg.sv
// Purpose: shared types of the default address decoder
// Assumes: nothing beyond the constants header
// Notes:   target codes are one-hot so each select is a single flop bit
package dad_pkg;

    // 32-bit processor address
    typedef logic [31:0] dad_addr_t;

    // decoded target, one-hot, bit 0 means no target
    typedef enum logic [5:0] {
        dad_tgt_none   = 6'h01,
        dad_tgt_pio    = 6'h02,
        dad_tgt_mc     = 6'h04,
        dad_tgt_hb     = 6'h08,
        dad_tgt_boot_a = 6'h10,
        dad_tgt_boot_b = 6'h20
    } dad_target_e;

endpackage

// File: core/dad_match_if.sv
// Purpose: carries the address to the window matcher and the hits back
// Assumes: one window per hit bit, order as in the constants header
// Notes:   purely combinational path inside one clock domain
`timescale 1ns/1ps
`include "dad_defs.svh"

interface dad_match_if;
    dad_pkg::dad_addr_t        addr; // address under test
    logic [`DAD_WIN_N-1:0]     hit;  // one bit per default window

    // decoder side drives the address
    modport dec (output addr, input hit);
    // matcher side answers with hits
    modport mat (input addr, output hit);
endinterface

// File: core/dad_win_match.sv
// Purpose: compares one address against every default window
// Assumes: windows are aligned blocks described by base and mask
// Notes:   windows do not overlap, so at most one hit bit is set
`timescale 1ns/1ps
`include "dad_defs.svh"

module dad_win_match (
    // address in, hits out
    dad_match_if.mat m
);

    // true when the masked address equals the window base
    function automatic logic in_win(input dad_pkg::dad_addr_t a,
                                    input dad_pkg::dad_addr_t base,
                                    input dad_pkg::dad_addr_t mask);
        in_win = ((a & mask) == base);
    endfunction

    // one comparator per window; the gaps between them hit nothing
    assign m.hit[`DAD_WIN_PIO]  = in_win(m.addr, `DAD_PIO_BASE, `DAD_PIO_MASK);
    assign m.hit[`DAD_WIN_MC]   = in_win(m.addr, `DAD_MC_BASE, `DAD_MC_MASK);
    assign m.hit[`DAD_WIN_HB]   = in_win(m.addr, `DAD_HB_BASE, `DAD_HB_MASK);
    assign m.hit[`DAD_WIN_BOOT] = in_win(m.addr, `DAD_BOOT_BASE, `DAD_BOOT_MASK);

endmodule

// File: core/dad_decoder.sv
// Purpose: default processor address decoder with boot bank steering
// Assumes: requests and map controls come from logic on mclk; the bank
//          select comes from a board strap or pin and is synchronised
// Notes:   one cycle of latency from request to registered selects
//
// Contract
// RULE1: default map holds after reset until reprogrammed
// RULE2: 80000000-8001FFFF goes to pci/isa i/o
// RULE3: FEF80000-FEF8FFFF goes to memory controller registers
// RULE4: FEFF0000-FEFFFFFF goes to host bridge registers
// RULE5: top 1MB from FFF00000 goes to boot flash
// RULE6: bank select clear picks A, set picks B
// RULE7: all gaps between windows decode no target
// RULE8: reset disables every pci map decoder
// RULE9: software programs pci decoders before relying
// RULE10: one processor controls map registers at once
// RULE11: at most one target select per access
`timescale 1ns/1ps
`include "dad_defs.svh"

module dad_decoder #(
    parameter int PCI_DEC_N = 4 // number of pci-side map decoders
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    // processor bus request
    input  wire logic                   cpu_req,
    input  wire dad_pkg::dad_addr_t     cpu_addr,
    // map control from the register logic
    input  wire logic                   map_reprog,
    input  wire logic                   pci_dec_wr,
    input  wire logic [PCI_DEC_N-1:0]   pci_dec_wdata,
    // boot bank strap, asynchronous
    input  wire logic                   boot_bank_select,
    // target selects
    output logic                        sel_pio,
    output logic                        sel_mc,
    output logic                        sel_hb,
    output logic                        sel_boot_a,
    output logic                        sel_boot_b,
    output logic                        no_target,
    // decode qualifiers
    output logic                        dec_valid,
    output logic [19:0]                 dec_offset,
    output logic                        default_map,
    // pci decoder enables
    output logic [PCI_DEC_N-1:0]        pci_dec_en
);

    // refuse a decoder count the enable vector cannot hold
    if (PCI_DEC_N < 1 || PCI_DEC_N > 32) begin : g_chk
        $error("PCI_DEC_N must lie between 1 and 32");
    end

    dad_pkg::dad_target_e        target_ff;      // registered target
    dad_pkg::dad_target_e        nxt_target;     // decoded target
    logic [5:0]                  tbits;          // target as raw bits
    logic                        valid_ff;       // decode strobe
    logic [19:0]                 offs_ff;        // low 20 bits of the request address
    logic                        defmap_ff;      // default map in force
    logic [PCI_DEC_N-1:0]        pcien_ff;       // pci decoder enables
    logic                        bank_s1_ff;     // strap sync, first stage
    logic                        bank_s2_ff;     // strap sync, second stage
    logic                        pci_prog_ff;    // helper: pci write seen
    dad_match_if                 mif();          // matcher connection

    // address goes to the matcher straight from the bus
    assign mif.addr = cpu_addr;

    // window comparators
    dad_win_match u_match (
        .m (mif)
    );

    // strap may change at any time, so two flops before use
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_s1_ff <= 1'b0;
            bank_s2_ff <= 1'b0;
        end else begin
            bank_s1_ff <= boot_bank_select;
            bank_s2_ff <= bank_s1_ff;
        end
    end

    // map hit vector to a target; a multi-hit code cannot occur
    // because the windows are disjoint, but is caught as none
    function automatic dad_pkg::dad_target_e pick(input logic [`DAD_WIN_N-1:0] hit,
                                                  input logic bank_b);
        unique case (hit)
            4'h0: begin
                pick = dad_pkg::dad_tgt_none; // gap in the map [RULE7]
            end
            4'h1: begin
                pick = dad_pkg::dad_tgt_pio; // [RULE2]
            end
            4'h2: begin
                pick = dad_pkg::dad_tgt_mc; // [RULE3]
            end
            4'h4: begin
                pick = dad_pkg::dad_tgt_hb; // [RULE4]
            end
            4'h8: begin
                // strap chooses which flash bank answers [RULE5] [RULE6]
                pick = bank_b ? dad_pkg::dad_tgt_boot_b : dad_pkg::dad_tgt_boot_a;
            end
            default: begin
                pick = dad_pkg::dad_tgt_none; // at most one select [RULE11]
            end
        endcase
    endfunction

    // next target: only the default map claims addresses here
    always_comb begin
        if (cpu_req && defmap_ff) begin
            nxt_target = pick(mif.hit, bank_s2_ff); // [RULE1]
        end else begin
            nxt_target = dad_pkg::dad_tgt_none;
        end
    end

    // target register; selects are idle between requests
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            target_ff <= dad_pkg::dad_tgt_none;
        end else begin
            target_ff <= nxt_target; // [RULE11]
        end
    end

    // strobe and window offset follow every request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            valid_ff <= `DAD_VALID_RST;
            offs_ff  <= `DAD_OFFS_RST;
        end else begin
            valid_ff <= cpu_req;
            if (cpu_req) begin
                // low 20 bits: first 1 MB of bank A or bank B [RULE6]
                offs_ff <= cpu_addr[19:0];
            end
        end
    end

    // default map stays until reprogramming; only reset restores it,
    // so a stray second pulse cannot bring it back by accident
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            defmap_ff <= `DAD_DEFMAP_RST; // [RULE1]
        end else if (map_reprog) begin
            defmap_ff <= 1'b0; // [RULE1]
        end
    end

    // pci decoders come up off and stay off until written
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pcien_ff <= {PCI_DEC_N{`DAD_PCIEN_RST}}; // [RULE8]
        end else if (pci_dec_wr) begin
            pcien_ff <= pci_dec_wdata; // [RULE9]
        end
    end

    // helper for checks: a pci decoder write has happened since reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pci_prog_ff <= 1'b0;
        end else if (pci_dec_wr) begin
            pci_prog_ff <= 1'b1;
        end
    end

    // outputs are flop bits with no gating
    assign tbits       = target_ff;
    assign no_target   = tbits[0];
    assign sel_pio     = tbits[1];
    assign sel_mc      = tbits[2];
    assign sel_hb      = tbits[3];
    assign sel_boot_a  = tbits[4];
    assign sel_boot_b  = tbits[5];
    assign dec_valid   = valid_ff;
    assign dec_offset  = offs_ff;
    assign default_map = defmap_ff;
    assign pci_dec_en  = pcien_ff;

    // checks, all on mclk and quiet in reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // request decoded by the default map
    sequence s_def_req;
        cpu_req && defmap_ff;
    endsequence

    // reprogramming pulse taken with no new reset
    sequence s_reprog;
        map_reprog ##1 !defmap_ff;
    endsequence

    a_one_select: assert property (
        $onehot(tbits)) // [RULE11]
        else $error("target select not one-hot");

    a_pio_route: assert property (
        s_def_req and (cpu_addr >= `DAD_PIO_BASE
        && cpu_addr <= (`DAD_PIO_BASE | ~`DAD_PIO_MASK))
        |=> sel_pio && dec_valid) // [RULE2]
        else $error("pci/isa i/o window not selected");

    a_mc_route: assert property (
        s_def_req and (cpu_addr >= `DAD_MC_BASE
        && cpu_addr <= (`DAD_MC_BASE | ~`DAD_MC_MASK))
        |=> sel_mc && dec_valid) // [RULE3]
        else $error("memory controller window not selected");

    a_hb_route: assert property (
        s_def_req and (cpu_addr >= `DAD_HB_BASE
        && cpu_addr <= (`DAD_HB_BASE | ~`DAD_HB_MASK))
        |=> sel_hb && dec_valid) // [RULE4]
        else $error("host bridge window not selected");

    a_boot_route: assert property (
        s_def_req and (cpu_addr >= `DAD_BOOT_BASE)
        |=> (sel_boot_a || sel_boot_b) && dec_offset == $past(cpu_addr[19:0])) // [RULE5]
        else $error("boot window not selected");

    a_boot_bank: assert property (
        s_def_req and (cpu_addr >= `DAD_BOOT_BASE)
        |=> (sel_boot_b == $past(bank_s2_ff)) && (sel_boot_a == !$past(bank_s2_ff))) // [RULE6]
        else $error("wrong boot bank selected");

    a_gap_none: assert property (
        s_def_req and !(cpu_addr >= `DAD_BOOT_BASE)
        and !((cpu_addr & `DAD_PIO_MASK) == `DAD_PIO_BASE)
        and !((cpu_addr & `DAD_MC_MASK) == `DAD_MC_BASE)
        and !((cpu_addr & `DAD_HB_MASK) == `DAD_HB_BASE)
        |=> no_target && dec_valid) // [RULE7]
        else $error("unmapped address selected a target");

    a_map_retire: assert property (
        s_reprog |=> !defmap_ff [*4]) // [RULE1]
        else $error("default map came back without reset");

    a_map_hold: assert property (
        defmap_ff && !map_reprog |=> defmap_ff) // [RULE1]
        else $error("default map dropped without reprogramming");

    a_pci_off: assert property (
        !pci_prog_ff |-> pcien_ff == '0) // [RULE8]
        else $error("pci decoder enabled before programming");

    a_idle_quiet: assert property (
        !cpu_req |=> !dec_valid ##0 no_target) // [RULE11]
        else $error("select raised with no request");

endmodule

// File: sim/dad_cpu_model.sv
// Purpose: processor bus master model issuing decode requests
// Assumes: the only master on the bus, requests launched on mclk
// Notes:   an idle bus shows the inverse of the address it held, so two releases in a row restore it
`timescale 1ns/1ps

module dad_cpu_model (
    // clock
    input  wire logic               mclk,
    // processor request
    output logic                    cpu_req,
    output dad_pkg::dad_addr_t      cpu_addr
);
    // idle bus at time zero
    initial begin
        cpu_req  = 1'b0;
        cpu_addr = 32'h00000000;
    end

    // one access per call, back to back when called every cycle
    task automatic access(input dad_pkg::dad_addr_t a);
        @(posedge mclk);
        cpu_req  <= 1'b1;
        cpu_addr <= a;
    endtask

    // release: address lines lose the last value so stale decodes show up
    task automatic release_bus();
        @(posedge mclk);
        cpu_req  <= 1'b0;
        cpu_addr <= ~cpu_addr;
    endtask
endmodule

// File: sim/dad_decoder_test.sv
// Purpose: self-checking bench for the default address decoder
// Assumes: one cycle from request to selects, strap settles within 4 cycles
// Notes:   driver queues expectations, a monitor compares on each answer
`timescale 1ns/1ps

module dad_decoder_test;
    logic               mclk = 1'b0;       // 40 MHz clock
    logic               resetn = 1'b0;     // async reset, low active
    logic               map_reprog = 1'b0; // retire default map
    logic               pci_dec_wr = 1'b0; // pci enable write
    logic [3:0]         pci_dec_wdata = 4'h0;
    logic               boot_bank_select = 1'b0;
    logic               cpu_req;
    dad_pkg::dad_addr_t cpu_addr;
    logic [5:0]         sel;               // {boot_b, boot_a, hb, mc, pio, none}
    logic               sel_pio, sel_mc, sel_hb, sel_boot_a, sel_boot_b, no_target;
    logic               dec_valid, default_map;
    logic [19:0]        dec_offset;
    logic [3:0]         pci_dec_en;
    logic [25:0]        exp_q[$];          // {target, offset} per request
    logic [25:0]        e;
    logic               bank_x = 1'b0;     // bank the strap has settled to
    logic               dm_x = 1'b1;       // default map expected in force
    int                 n_errors = 0;
    int                 cmp_count = 0;
    logic [31:0]        r;
    logic [31:0]        edge_a[16] = '{32'h80000000, 32'h8001FFFF, 32'h80020000, 32'h7FFFFFFF,
        32'h00000000, 32'hFEF80000, 32'hFEF8FFFF, 32'hFEF7FFFF, 32'hFEF90000, 32'hFEFF0000,
        32'hFEFFFFFF, 32'hFEFEFFFF, 32'hFF000000, 32'hFFEFFFFF, 32'hFFF00000, 32'hFFFFFFFF};
    logic [31:0]        base_a[5] = '{32'h80000000, 32'hFEF80000, 32'hFEFF0000, 32'hFFF00000, 0};
    logic [31:0]        mask_a[5] = '{32'h0001FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'h000FFFFF,
                                      32'hFFFFFFFF};

    assign sel = {sel_boot_b, sel_boot_a, sel_hb, sel_mc, sel_pio, no_target};

    // free running clock, 25 ns period
    always #12.5 mclk = ~mclk;

    dad_cpu_model u_dad_cpu_model (.mclk(mclk), .cpu_req(cpu_req), .cpu_addr(cpu_addr));

    dad_decoder #(.PCI_DEC_N(4)) u_dad_decoder (
        .mclk(mclk), .resetn(resetn), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
        .map_reprog(map_reprog), .pci_dec_wr(pci_dec_wr), .pci_dec_wdata(pci_dec_wdata),
        .boot_bank_select(boot_bank_select), .sel_pio(sel_pio), .sel_mc(sel_mc),
        .sel_hb(sel_hb), .sel_boot_a(sel_boot_a), .sel_boot_b(sel_boot_b),
        .no_target(no_target), .dec_valid(dec_valid), .dec_offset(dec_offset),
        .default_map(default_map), .pci_dec_en(pci_dec_en));

    // single comparison point
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    // target expected from the default window table
    function automatic logic [5:0] exp_tgt(input logic [31:0] a);
        if (!dm_x) return 6'h01;
        if (a >= 32'h80000000 && a <= 32'h8001FFFF) return 6'h02;
        if (a >= 32'hFEF80000 && a <= 32'hFEF8FFFF) return 6'h04;
        if (a >= 32'hFEFF0000 && a <= 32'hFEFFFFFF) return 6'h08;
        if (a >= 32'hFFF00000) return bank_x ? 6'h20 : 6'h10;
        return 6'h01;
    endfunction

    // queue the expectation, then issue the access
    task automatic go(input logic [31:0] a);
        exp_q.push_back({exp_tgt(a), a[19:0]});
        u_dad_cpu_model.access(a);
    endtask

    // reset pulse; outputs checked once the strap sync has settled
    task automatic do_reset(input int n);
        u_dad_cpu_model.release_bus();
        resetn <= 1'b0;
        repeat (n) @(posedge mclk);
        resetn <= 1'b1;
        dm_x = 1'b1;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk(default_map, 1);
        chk(pci_dec_en, 0);
        chk(dec_valid, 0);
    endtask

    // strap change, bus idle while it settles
    task automatic set_bank(input logic b);
        u_dad_cpu_model.release_bus();
        boot_bank_select <= b;
        repeat (4) @(posedge mclk);
        bank_x = b;
    endtask

    task automatic finish_test();
        chk(32'(exp_q.size()), 0);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // monitor: compare each answer with the oldest note, idle means no target
    always @(negedge mclk) begin
        if (resetn === 1'b1 && dec_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(1, 0); // answer without request
            else begin
                e = exp_q.pop_front();
                chk(sel, e[25:20]);
                chk(dec_offset, e[19:0]);
                chk($onehot(sel), 1);
            end
        end else if (resetn === 1'b1) chk(sel, 6'h01);
    end

    // watchdog, well past the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        finish_test();
    end

    // main sequence
    initial begin
        r = $urandom(32'hDC725C56);
        repeat (20) @(posedge mclk);
        do_reset(1);
        for (int b = 0; b < 2; b++) begin
            set_bank(b[0]);
            foreach (edge_a[i]) go(edge_a[i]);
        end
        set_bank(1'b0);
        for (int i = 0; i < 60; i++) begin
            r = $urandom % 5;
            go(base_a[r] | ($urandom & mask_a[r]));
            if ($urandom % 3 == 0) u_dad_cpu_model.release_bus();
            if (i == 30) set_bank(1'b1);
        end
        // drop the strobe, else the last address is decoded again with no note queued
        u_dad_cpu_model.release_bus();
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            @(posedge mclk);
            pci_dec_wr <= 1'b1;
            pci_dec_wdata <= r[3:0];
            @(posedge mclk);
            pci_dec_wr <= 1'b0;
            @(negedge mclk);
            chk(pci_dec_en, r[3:0]);
        end
        do_reset(3);
        go(32'h80000010);
        map_reprog <= 1'b1;
        dm_x = 1'b0;
        go(32'hFEF80000);
        map_reprog <= 1'b0;
        go(32'hFFF00010);
        u_dad_cpu_model.release_bus();
        @(negedge mclk);
        chk(default_map, 0);
        // let the retired map sit a few cycles so the no-comeback check runs out
        repeat (4) @(posedge mclk);
        chk(default_map, 0);
        do_reset(2);
        go(32'hFFF00020);
        u_dad_cpu_model.release_bus();
        repeat (3) @(posedge mclk);
        finish_test();
    end
endmodule
